// file: link_cap_pkg.sv
// package with register map, field layout and reset values of the link capabilities block
package link_cap_pkg;

    // register byte addresses (word aligned, 32-bit data)
    localparam logic [11:0] LINK_CAP_ADDR = 12'h04c;
    localparam logic [11:0] LINK_CTRL_ADDR = 12'h050;
    localparam logic [11:0] UNLOCK_ADDR = 12'h100;
    localparam logic [11:0] STATUS_ADDR = 12'h104;

    // field positions of link_capabilities
    localparam int SPEED_LSB = 0;
    localparam int WIDTH_LSB = 4;
    localparam int PSS_LSB = 10;
    localparam int L0S_LSB = 12;
    localparam int L1_LSB = 15;
    localparam int REFCLK_BIT = 18;
    localparam int SDOWN_BIT = 19;
    localparam int DLACT_BIT = 20;
    localparam int BWN_BIT = 21;
    localparam int PORT_LSB = 24;

    // link control field position of the common reference clock bit
    localparam int COMMON_REFCLK_CFG_BIT = 6;
    // unlock register bit
    localparam int UNLOCK_BIT = 0;

    // field values
    localparam logic [3:0] SPEED_GEN1 = 4'h1;
    localparam logic [3:0] SPEED_GEN2 = 4'h2;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [5:0] WIDTH_X2 = 6'h02;
    localparam logic [5:0] WIDTH_X4 = 6'h04;
    localparam logic [1:0] PSS_L0S_L1 = 2'h3;
    localparam logic [2:0] L0S_SEPARATE = 3'h5;
    localparam logic [2:0] L0S_COMMON = 3'h3;
    localparam logic [2:0] L1_RESET = 3'h2;
    localparam logic REFCLK_RESET = 1'b0;
    localparam logic BWN_RESET = 1'b0;
    localparam logic [7:0] PORT_MAX = 8'h07;

    // axi4-lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // lockable capability fields held in flops
    typedef struct packed {
        logic bwn;
        logic dlact;
        logic sdown;
        logic refclk;
        logic [2:0] l1_lat;
        logic [5:0] width;
    } lock_fields_t;

    // status seen by software
    typedef struct packed {
        logic [5:0] width;
        logic common_clk;
        logic unlocked;
    } link_status_t;

endpackage : link_cap_pkg

// file: link_cap_reg.sv
// link capabilities register bank behind an axi4-lite slave
// Overview of operation
// - speed field reads 0x1, 2.5 Gbps
// - width field resets to x4, lockable writes
// - invalid width makes link run x1
// - power state support reads constant 0x3
// - l0s latency 0x5 separate, 0x3 common
// - common clock bit selects l0s latency
// - l1 exit latency defaults to 0x2
// - refclk removal bit defaults to zero
// - surprise down: downstream one, upstream zero
// - dl active report: downstream one, upstream zero
// - bandwidth notify defaults zero, upstream stays zero
// - bits 31:24 return port number 0..7
`timescale 1ns/100ps

module link_cap_reg #(
    parameter logic [7:0] PORT_NUM = 8'h00,
    parameter bit IS_UPSTREAM = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // lane count the link trainer must use
    output logic [5:0] train_width_out,
    output logic common_refclk_cfg_out
);

    initial begin
        if (PORT_NUM > link_cap_pkg::PORT_MAX) begin
            $error("port number out of range");
        end
        if (IS_UPSTREAM && PORT_NUM != 8'h00) begin
            $error("upstream port must be port 0");
        end
    end

    // surprise down and dl active reset to one downstream, zero upstream
    localparam logic DS_ONE = IS_UPSTREAM ? 1'b0 : 1'b1;

    link_cap_pkg::lock_fields_t lock_r;
    logic common_refclk_cfg_r;
    logic lockable_write_r;

    // write channel capture: address and data may arrive in either order
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic wr_fire;
    logic [31:0] cap_word;
    logic [31:0] ctrl_word;
    logic [31:0] unlock_word;
    logic [31:0] status_word;
    logic [2:0] l0s_latency;
    logic width_valid;
    link_cap_pkg::link_status_t status_s;

    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = !w_held_r && !bvalid_r;
    assign s_axi_arready_out = !rvalid_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_in;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata_in;
            wstrb_r <= s_axi_wstrb_in;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bvalid_r <= 1'b0;
            bresp_r <= link_cap_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            case (awaddr_r[11:2])
                link_cap_pkg::LINK_CAP_ADDR[11:2],
                link_cap_pkg::LINK_CTRL_ADDR[11:2],
                link_cap_pkg::UNLOCK_ADDR[11:2],
                link_cap_pkg::STATUS_ADDR[11:2]: bresp_r <= link_cap_pkg::RESP_OKAY;
                default: bresp_r <= link_cap_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lockable_write_r <= 1'b0;
        end else if (wr_fire && awaddr_r[11:2] == link_cap_pkg::UNLOCK_ADDR[11:2] && wstrb_r[0]) begin
            lockable_write_r <= wdata_r[link_cap_pkg::UNLOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            common_refclk_cfg_r <= 1'b0;
        end else if (wr_fire && awaddr_r[11:2] == link_cap_pkg::LINK_CTRL_ADDR[11:2] && wstrb_r[0]) begin
            common_refclk_cfg_r <= wdata_r[link_cap_pkg::COMMON_REFCLK_CFG_BIT];
        end
    end

    // lockable fields, written byte lane by byte lane only while unlocked
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_r.width <= link_cap_pkg::WIDTH_X4;
            lock_r.l1_lat <= link_cap_pkg::L1_RESET;
            lock_r.refclk <= link_cap_pkg::REFCLK_RESET;
            lock_r.sdown <= DS_ONE;
            lock_r.dlact <= DS_ONE;
            lock_r.bwn <= link_cap_pkg::BWN_RESET;
        end else if (wr_fire && lockable_write_r
                     && awaddr_r[11:2] == link_cap_pkg::LINK_CAP_ADDR[11:2]) begin
            if (wstrb_r[0]) begin
                lock_r.width[3:0] <= wdata_r[7:4];
            end
            if (wstrb_r[1]) begin
                lock_r.width[5:4] <= wdata_r[9:8];
                lock_r.l1_lat[0] <= wdata_r[link_cap_pkg::L1_LSB];
            end
            if (wstrb_r[2]) begin
                lock_r.l1_lat[2:1] <= wdata_r[17:16];
                lock_r.refclk <= wdata_r[link_cap_pkg::REFCLK_BIT];
                // upstream keeps downstream-only capabilities at zero
                lock_r.sdown <= wdata_r[link_cap_pkg::SDOWN_BIT] & DS_ONE;
                lock_r.dlact <= wdata_r[link_cap_pkg::DLACT_BIT] & DS_ONE;
                lock_r.bwn <= wdata_r[link_cap_pkg::BWN_BIT] & DS_ONE;
            end
        end
    end

    // l0s latency tracks the clocking mode, so it is not stored
    assign l0s_latency = common_refclk_cfg_r ? link_cap_pkg::L0S_COMMON
                                             : link_cap_pkg::L0S_SEPARATE;

    always_comb begin
        cap_word = 32'h0000_0000; // reserved 23:22 stay zero
        cap_word[link_cap_pkg::SPEED_LSB +: 4] = link_cap_pkg::SPEED_GEN1;
        cap_word[link_cap_pkg::WIDTH_LSB +: 6] = lock_r.width;
        cap_word[link_cap_pkg::PSS_LSB +: 2] = link_cap_pkg::PSS_L0S_L1;
        cap_word[link_cap_pkg::L0S_LSB +: 3] = l0s_latency;
        cap_word[link_cap_pkg::L1_LSB +: 3] = lock_r.l1_lat;
        cap_word[link_cap_pkg::REFCLK_BIT] = lock_r.refclk;
        cap_word[link_cap_pkg::SDOWN_BIT] = lock_r.sdown;
        cap_word[link_cap_pkg::DLACT_BIT] = lock_r.dlact;
        cap_word[link_cap_pkg::BWN_BIT] = lock_r.bwn;
        cap_word[link_cap_pkg::PORT_LSB +: 8] = PORT_NUM;
    end

    // only x1, x2 and x4 exist on this port; anything else trains as x1
    always_comb begin
        case (lock_r.width)
            link_cap_pkg::WIDTH_X1,
            link_cap_pkg::WIDTH_X2,
            link_cap_pkg::WIDTH_X4: width_valid = 1'b1;
            default: width_valid = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            train_width_out <= link_cap_pkg::WIDTH_X4;
        end else begin
            train_width_out <= width_valid ? lock_r.width : link_cap_pkg::WIDTH_X1;
        end
    end

    assign common_refclk_cfg_out = common_refclk_cfg_r;

    assign status_s.width = train_width_out;
    assign status_s.common_clk = common_refclk_cfg_r;
    assign status_s.unlocked = lockable_write_r;
    assign ctrl_word = {25'h0, common_refclk_cfg_r, 6'h00};
    assign unlock_word = {31'h0, lockable_write_r};
    assign status_word = {24'h0, status_s};

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= link_cap_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_r <= 1'b1;
            rresp_r <= link_cap_pkg::RESP_OKAY;
            case (s_axi_araddr_in[11:2])
                link_cap_pkg::LINK_CAP_ADDR[11:2]: rdata_r <= cap_word;
                link_cap_pkg::LINK_CTRL_ADDR[11:2]: rdata_r <= ctrl_word;
                link_cap_pkg::UNLOCK_ADDR[11:2]: rdata_r <= unlock_word;
                link_cap_pkg::STATUS_ADDR[11:2]: rdata_r <= status_word;
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= link_cap_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

endmodule : link_cap_reg

// file: link_cap_reg_checker.sv
// port checker of the link capabilities register bank
`timescale 1ns/100ps
module link_cap_reg_checker #(
    parameter logic [7:0] PORT_NUM = 8'h00,
    parameter bit IS_UPSTREAM = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [5:0] train_width_out,
    input wire logic common_refclk_cfg_out
);
    logic [11:0] rd_addr_r;
    logic cap_rd;
    logic unmapped;
    // address of the read in flight, so read data can be judged per register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_addr_r <= 12'h000;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rd_addr_r <= s_axi_araddr_in;
        end
    end
    assign cap_rd = s_axi_rvalid_out && (rd_addr_r[11:2] == link_cap_pkg::LINK_CAP_ADDR[11:2]);
    assign unmapped = !(rd_addr_r[11:2] inside {link_cap_pkg::LINK_CAP_ADDR[11:2], link_cap_pkg::LINK_CTRL_ADDR[11:2],
        link_cap_pkg::UNLOCK_ADDR[11:2], link_cap_pkg::STATUS_ADDR[11:2]});
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    AST_SPEED: assert property (cap_rd |-> s_axi_rdata_out[3:0] == link_cap_pkg::SPEED_GEN1)
        else $error("speed field wrong");
    AST_PSS: assert property (cap_rd |-> s_axi_rdata_out[11:10] == link_cap_pkg::PSS_L0S_L1)
        else $error("power state support wrong");
    AST_L0S: assert property (cap_rd |-> s_axi_rdata_out[14:12] ==
        (common_refclk_cfg_out ? link_cap_pkg::L0S_COMMON : link_cap_pkg::L0S_SEPARATE)) else $error("l0s latency wrong");
    AST_PORT: assert property (cap_rd |-> s_axi_rdata_out[31:22] == {PORT_NUM, 2'h0})
        else $error("port or reserved bits wrong");
    AST_TRAIN: assert property (cap_rd |-> train_width_out ==
        ((s_axi_rdata_out[9:4] inside {6'h01, 6'h02, 6'h04}) ? s_axi_rdata_out[9:4] : 6'h01))
        else $error("train width wrong");
    AST_UNMAP: assert property (s_axi_rvalid_out && unmapped |-> s_axi_rresp_out == link_cap_pkg::RESP_SLVERR
        && s_axi_rdata_out == 32'h0) else $error("unmapped read answered wrongly");
    AST_RD_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
        && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("read answer dropped");
    AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write answer dropped");
    COV_CAP: cover property (cap_rd);
    COV_UNMAP: cover property (s_axi_rvalid_out && unmapped);
    COV_BERR: cover property (s_axi_bvalid_out && s_axi_bresp_out == link_cap_pkg::RESP_SLVERR);
endmodule : link_cap_reg_checker
bind link_cap_reg link_cap_reg_checker #(.PORT_NUM(PORT_NUM), .IS_UPSTREAM(IS_UPSTREAM)) i_checker (.*);

// file: tb.sv
// self-checking bench of the link capabilities register bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("wrong value t=%0t %h %h", $time, g, e); end end
module tb;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wrdy, bv, arr, rv, cc, common_refclk_cfg_m, unl_m;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rd, cap_m, d, seed = 32'h00013359;
    logic [3:0] ws = 4'h0;
    logic [1:0] bresp, rresp;
    logic [5:0] tw;
    logic [11:0] tbl [4] = '{12'h04c, 12'h050, 12'h100, 12'h1f0};
    int fails = 0, n_checks = 0, cyc = 0;
    link_cap_reg #(.PORT_NUM(8'h05)) i_dut (.sys_clk_in(clk), .arst_n_in(rst_n), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .train_width_out(tw), .common_refclk_cfg_out(cc));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            12'h04c: return {cap_m[31:15], common_refclk_cfg_m ? 3'h3 : 3'h5, cap_m[11:0]};
            12'h050: return {25'h0, common_refclk_cfg_m, 6'h00};
            12'h100: return {31'h0, unl_m};
            12'h104: return {24'h0, exp_tw(), common_refclk_cfg_m, unl_m};
            default: return 32'h0;
        endcase
    endfunction : exp_rd
    // status shows the width the link trains with, not the raw field
    function automatic logic [5:0] exp_tw();
        return (cap_m[9:4] inside {6'h01, 6'h02, 6'h04}) ? cap_m[9:4] : 6'h01;
    endfunction : exp_tw
    function automatic logic [1:0] exp_resp(input logic [11:0] a);
        return (a inside {12'h04c, 12'h050, 12'h100, 12'h104}) ? 2'h0 : 2'h2;
    endfunction : exp_resp
    task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
        logic [31:0] m;
        logic hs_aw, hs_w, done;
        logic [1:0] resp;
        @(posedge clk);
        awa <= a; wd <= dd; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        // sample settled handshakes mid-cycle; they take effect at the next rising edge
        do begin
            @(negedge clk);
            hs_aw = awv && awr;
            hs_w = wv && wrdy;
            done = bv && br;
            resp = bresp;
            @(posedge clk);
            if (hs_aw) awv <= 1'b0;
            if (hs_w) wv <= 1'b0;
        end while (!done);
        br <= 1'b0;
        `CHK(resp, exp_resp(a))
        // only the lockable fields move, and only in the lanes strobed
        m = 32'h003f83f0 & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (a == 12'h04c && unl_m) cap_m = (cap_m & ~m) | (dd & m);
        if (a == 12'h050 && s[0]) common_refclk_cfg_m = dd[6];
        if (a == 12'h100 && s[0]) unl_m = dd[0];
    endtask : wr
    task automatic rdchk(input logic [11:0] a);
        logic hs_ar, done;
        logic [31:0] rdat;
        logic [1:0] resp;
        logic [5:0] twid;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(negedge clk);
            hs_ar = arv && arr;
            done = rv && rr;
            rdat = rd;
            resp = rresp;
            twid = tw;
            @(posedge clk);
            if (hs_ar) arv <= 1'b0;
        end while (!done);
        rr <= 1'b0;
        `CHK(rdat, exp_rd(a))
        `CHK(resp, exp_resp(a))
        `CHK(twid, exp_tw())
    endtask : rdchk
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        cap_m = 32'h05195c41;
        common_refclk_cfg_m = 1'b0;
        unl_m = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(12'h04c);
        wr(12'h04c, 32'h0, 4'hf);
        rdchk(12'h04c);
        wr(12'h050, 32'h40, 4'h1);
        rdchk(12'h04c);
        wr(12'h100, 32'h1, 4'h1);
        wr(12'h04c, 32'hffffffff, 4'hf);
        rdchk(12'h04c);
        wr(12'h04c, 32'h00000020, 4'h1);
        rdchk(12'h104);
        rdchk(12'h1f0);
        repeat (80) begin
            d = rnd();
            if (d[2]) wr(tbl[d[1:0]], rnd(), d[7:4]);
            else rdchk(d[3] ? 12'h104 : tbl[d[1:0]]);
        end
        results();
    end
endmodule : tb
